// ### mac_cfg_pkg.sv
// Package with offsets, field positions and reset values for the MAC config register bank
package mac_cfg_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_RX_CFG = 4'hC;
    localparam logic [3:0] OFS_TX_CFG = 4'hD;
    localparam logic [3:0] OFS_DP_CFG = 4'hE;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hF;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ISR = 8'h80;
    // Rx config fields
    localparam int RC_MONITOR = 5;
    localparam int RC_PROMISC = 4;
    localparam int RC_MCAST = 3;
    localparam int RC_BCAST = 2;
    localparam int RC_SHORT = 1;
    localparam int RC_SAVE_ERR = 0;
    localparam logic [7:0] RC_MASK = 8'h3F;
    // Tx config fields
    localparam int TC_FDX = 7;
    localparam int TC_PAD_DIS = 6;
    localparam int TC_LATE_RETRY = 5;
    localparam int TC_LB_HI = 2;
    localparam int TC_LB_LO = 1;
    localparam int TC_NO_CRC = 0;
    localparam logic [7:0] TC_MASK = 8'hE7;
    localparam logic [7:0] DC_MASK = 8'h01;
    localparam logic [7:0] IM_MASK = 8'h7F;
    localparam logic [7:0] RS_MASK = 8'h77;
    localparam int DC_WTS = 0;
    // Rx status fields
    localparam int RS_RSVD = 7;
    localparam int RS_DISABLED = 6;
    localparam int RS_MCAST = 5;
    localparam int RS_MISSED = 4;
    localparam int RS_ZERO_BIT = 3;
    localparam int RS_ALIGN = 2;
    localparam int RS_CRC = 1;
    localparam int RS_INTACT = 0;
    // Interrupt bit positions (status and mask)
    localparam int IRQ_DMA = 6;
    localparam int IRQ_TALLY = 5;
    localparam int IRQ_OVW = 4;
    localparam int IRQ_TXE = 3;
    localparam int IRQ_RXE = 2;
    localparam int IRQ_PTX = 1;
    localparam int IRQ_PRX = 0;
    localparam int IRQ_N = 7;
    localparam int TALLY_MSB = 7;
    typedef enum logic [1:0] {
        LB_NORMAL = 2'h0,
        LB_MAC = 2'h1,
        LB_PHY = 2'h2,
        LB_RSVD = 2'h3
    } loopback_t;
endpackage : mac_cfg_pkg

// ### tally_counter.sv
// Clear-on-read saturating-free error tally counter
`timescale 1ns/10ps
`default_nettype none
module tally_counter #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_inc,
    input wire logic i_rd_clr,
    output logic [WIDTH-1:0] o_count,
    output logic o_msb_rise
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        // A read clears; an event in the same cycle still counts once
        if (i_rd_clr) begin
            count_nxt = '0;
        end
        if (i_inc) begin
            count_nxt = count_nxt + WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign o_count = count_r;
    assign o_msb_rise = count_nxt[WIDTH-1] & ~count_r[WIDTH-1];
endmodule : tally_counter
`default_nettype wire

// ### rx_filter.sv
// Receive address filter decision from config bits and frame attributes
`timescale 1ns/10ps
`default_nettype none
module rx_filter (
    input wire logic i_monitor_only,
    input wire logic i_accept_all_unicast,
    input wire logic i_accept_multicast,
    input wire logic i_accept_broadcast,
    input wire logic i_accept_short_frames,
    input wire logic i_save_error_frames,
    input wire logic i_da_match,
    input wire logic i_da_multicast,
    input wire logic i_da_broadcast,
    input wire logic i_hash_hit,
    input wire logic i_short,
    input wire logic i_has_error,
    output logic o_addr_ok,
    output logic o_accept,
    output logic o_store
);
    logic unicast_ok;
    logic mcast_ok;
    logic bcast_ok;

    assign unicast_ok = ~i_da_multicast & (i_da_match | i_accept_all_unicast); // [RULE_02]
    assign mcast_ok = i_da_multicast & ~i_da_broadcast & i_accept_multicast & i_hash_hit; // [RULE_03]
    assign bcast_ok = i_da_broadcast & i_accept_broadcast; // [RULE_04]
    assign o_addr_ok = unicast_ok | mcast_ok | bcast_ok;
    assign o_accept = o_addr_ok
        & (~i_short | i_accept_short_frames) // [RULE_05]
        & (~i_has_error | i_save_error_frames); // [RULE_06]
    // Monitor mode still checks address and CRC but keeps memory untouched
    assign o_store = o_accept & ~i_monitor_only; // [RULE_01]
endmodule : rx_filter
`default_nettype wire

// ### mac_rx_tx_config_regs.sv
// Page-0 receive, transmit, data-port and interrupt config/status registers of the MAC
// Contract
// [RULE_01] Monitor mode checks frames, stores none
// [RULE_02] Promiscuous accepts every unicast frame
// [RULE_03] Multicast accepted only on hash hit
// [RULE_04] Broadcast accepted when enabled
// [RULE_05] Short frames accepted when enabled
// [RULE_06] Errored frames saved when enabled
// [RULE_07] Full duplex is OR of two bits; the code forces it low while i_internal_phy is set
// [RULE_08] Pad short frames unless disabled
// [RULE_09] Retry late collisions when enabled
// [RULE_10] Two-bit loopback mode select
// [RULE_11] Append CRC unless inhibited
// [RULE_12] Alignment tally counts address-passed frames
// [RULE_13] CRC tally counts address-passed frames
// [RULE_14] Tallies clear on host read
// [RULE_15] Word transfer select sets port width
// [RULE_16] Seven interrupt enables, reset disabled
// [RULE_17] Writing one clears a status flag
// [RULE_18] Tally MSB sets overflow flag
// [RULE_19] Interrupt while flag and mask set
// [RULE_20] Receive status bit layout
`timescale 1ns/10ps
`default_nettype none
module mac_rx_tx_config_regs (
    input wire logic i_clk,
    input wire logic i_srst,
    // Host register port
    input wire logic [mac_cfg_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [mac_cfg_pkg::DATA_W-1:0] i_wdata,
    output logic [mac_cfg_pkg::DATA_W-1:0] o_rdata,
    // Receiver frame end report
    input wire logic i_rx_done,
    input wire logic i_rx_da_match,
    input wire logic i_rx_da_multicast,
    input wire logic i_rx_da_broadcast,
    input wire logic i_rx_hash_hit,
    input wire logic i_rx_short,
    input wire logic i_rx_align_err,
    input wire logic i_rx_crc_err,
    input wire logic i_rx_missed,
    input wire logic i_rx_disabled,
    // Other interrupt sources
    input wire logic i_dma_done,
    input wire logic i_ring_overwrite,
    input wire logic i_tx_done,
    input wire logic i_tx_error,
    // Duplex inputs from media control and PHY selection
    input wire logic i_media_control_fdx,
    input wire logic i_internal_phy,
    // Receiver controls
    output logic o_rx_accept,
    output logic o_rx_store,
    // Transmitter controls, data-port width select and interrupt output
    output logic o_full_duplex,
    output logic o_pad_enable,
    output logic o_late_collision_retry,
    output logic [1:0] o_loopback_select,
    output logic o_append_crc,
    output logic o_word_transfer_select,
    output logic o_irq
);
    import mac_cfg_pkg::*;

    logic [7:0] rx_cfg_r;
    logic [7:0] tx_cfg_r;
    logic [7:0] dp_cfg_r;
    logic [7:0] irq_mask_r;
    logic [7:0] rx_status_r;
    logic [IRQ_N-1:0] irq_status_r;
    logic [IRQ_N-1:0] irq_set;
    logic [IRQ_N-1:0] irq_clr;
    logic [7:0] align_cnt;
    logic [7:0] crc_cnt;
    logic align_msb_rise;
    logic crc_msb_rise;
    logic addr_ok;
    logic accept;
    logic store;
    logic frame_err;
    logic align_inc;
    logic crc_inc;
    logic rd_align;
    logic rd_crc;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Configuration registers, write only from the host
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_cfg_r <= RST_ZERO;
            tx_cfg_r <= RST_ZERO;
            dp_cfg_r <= RST_ZERO;
            irq_mask_r <= RST_ZERO; // [RULE_16]
        end else if (i_wr) begin
            if (hit(i_addr, OFS_RX_CFG)) begin
                rx_cfg_r <= i_wdata & RC_MASK;
            end
            if (hit(i_addr, OFS_TX_CFG)) begin
                tx_cfg_r <= i_wdata & TC_MASK;
            end
            if (hit(i_addr, OFS_DP_CFG)) begin
                dp_cfg_r <= i_wdata & DC_MASK;
            end
            if (hit(i_addr, OFS_IRQ_MASK)) begin
                irq_mask_r <= i_wdata & IM_MASK; // [RULE_16]
            end
        end
    end

    rx_filter u_rx_filter (
        .i_monitor_only(rx_cfg_r[RC_MONITOR]),
        .i_accept_all_unicast(rx_cfg_r[RC_PROMISC]),
        .i_accept_multicast(rx_cfg_r[RC_MCAST]),
        .i_accept_broadcast(rx_cfg_r[RC_BCAST]),
        .i_accept_short_frames(rx_cfg_r[RC_SHORT]),
        .i_save_error_frames(rx_cfg_r[RC_SAVE_ERR]),
        .i_da_match(i_rx_da_match),
        .i_da_multicast(i_rx_da_multicast),
        .i_da_broadcast(i_rx_da_broadcast),
        .i_hash_hit(i_rx_hash_hit),
        .i_short(i_rx_short),
        .i_has_error(frame_err),
        .o_addr_ok(addr_ok),
        .o_accept(accept),
        .o_store(store)
    );

    assign frame_err = i_rx_align_err | i_rx_crc_err;
    assign o_rx_accept = i_rx_done & accept;
    assign o_rx_store = i_rx_done & store; // [RULE_01]

    // Tally counters only see frames that passed address recognition
    assign align_inc = i_rx_done & addr_ok & i_rx_align_err; // [RULE_12]
    assign crc_inc = i_rx_done & addr_ok & i_rx_crc_err; // [RULE_13]
    assign rd_align = i_rd & hit(i_addr, OFS_TX_CFG);
    assign rd_crc = i_rd & hit(i_addr, OFS_DP_CFG);

    tally_counter #(.WIDTH(DATA_W)) u_align_tally (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_inc(align_inc),
        .i_rd_clr(rd_align), // [RULE_14]
        .o_count(align_cnt),
        .o_msb_rise(align_msb_rise)
    );

    tally_counter #(.WIDTH(DATA_W)) u_crc_tally (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_inc(crc_inc),
        .i_rd_clr(rd_crc), // [RULE_14]
        .o_count(crc_cnt),
        .o_msb_rise(crc_msb_rise)
    );

    // Receive status latches the last completed frame, except the disabled bit, which follows i_rx_disabled every cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_status_r <= RST_ZERO;
        end else begin
            rx_status_r[RS_RSVD] <= 1'b0;
            rx_status_r[RS_DISABLED] <= i_rx_disabled; // [RULE_20]
            if (i_rx_done) begin
                rx_status_r[RS_MCAST] <= i_rx_da_multicast; // [RULE_20]
                rx_status_r[RS_MISSED] <= i_rx_missed;
                rx_status_r[RS_ZERO_BIT] <= 1'b0;
                rx_status_r[RS_ALIGN] <= i_rx_align_err;
                rx_status_r[RS_CRC] <= i_rx_crc_err;
                rx_status_r[RS_INTACT] <= ~frame_err & ~i_rx_missed; // [RULE_20]
            end
        end
    end

    // Interrupt status: set wins over a same-cycle write-one clear
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DMA] = i_dma_done;
        irq_set[IRQ_TALLY] = align_msb_rise | crc_msb_rise; // [RULE_18]
        irq_set[IRQ_OVW] = i_ring_overwrite;
        irq_set[IRQ_TXE] = i_tx_error;
        irq_set[IRQ_RXE] = i_rx_done & (frame_err | i_rx_missed);
        irq_set[IRQ_PTX] = i_tx_done;
        irq_set[IRQ_PRX] = o_rx_store & ~frame_err;
    end

    assign irq_clr = (i_wr && hit(i_addr, OFS_IRQ_STATUS)) ? i_wdata[IRQ_N-1:0] : '0;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_status_r <= RST_ZERO[IRQ_N-1:0];
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set; // [RULE_17]
        end
    end

    assign o_irq = |(irq_status_r & irq_mask_r[IRQ_N-1:0]); // [RULE_19]

    // Read mux; the same offsets hold different registers for reads
    always_comb begin
        o_rdata = RST_ZERO;
        unique case (i_addr)
            OFS_RX_CFG: o_rdata = rx_status_r & RS_MASK; // [RULE_20]
            OFS_TX_CFG: o_rdata = align_cnt;
            OFS_DP_CFG: o_rdata = crc_cnt;
            OFS_IRQ_STATUS: o_rdata = {1'b0, irq_status_r};
            default: o_rdata = RST_ZERO;
        endcase
    end

    // Internal PHY fixes duplex itself, so both host bits are ignored
    assign o_full_duplex = ~i_internal_phy
        & (tx_cfg_r[TC_FDX] | i_media_control_fdx); // [RULE_07]
    assign o_pad_enable = ~tx_cfg_r[TC_PAD_DIS]; // [RULE_08]
    assign o_late_collision_retry = tx_cfg_r[TC_LATE_RETRY]; // [RULE_09]
    assign o_loopback_select = tx_cfg_r[TC_LB_HI:TC_LB_LO]; // [RULE_10]
    assign o_append_crc = ~tx_cfg_r[TC_NO_CRC]; // [RULE_11]
    assign o_word_transfer_select = dp_cfg_r[DC_WTS]; // [RULE_15]
endmodule : mac_rx_tx_config_regs
`default_nettype wire

// ### mac_cfg_sva.sv
// Assertions on the MAC config register bank ports
`timescale 1ns/10ps
`default_nettype none
module mac_cfg_chk
    import mac_cfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_media_control_fdx,
    input wire logic i_internal_phy,
    input wire logic o_rx_store,
    input wire logic o_full_duplex,
    input wire logic o_pad_enable,
    input wire logic o_late_collision_retry,
    input wire logic [1:0] o_loopback_select,
    input wire logic o_append_crc,
    input wire logic o_word_transfer_select
);
    logic [7:0] rc_r;
    wire logic tx_wr = i_wr && i_addr == OFS_TX_CFG;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // The receive config cannot be read back, so keep a shadow of it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rc_r <= 8'h00;
        end else if (i_wr && i_addr == OFS_RX_CFG) begin
            rc_r <= i_wdata;
        end
    end
    AST_PAD: assert property (
        tx_wr |=> o_pad_enable != $past(i_wdata[TC_PAD_DIS]))
        else $error("pad enable wrong");
    AST_RETRY: assert property (
        tx_wr |=> o_late_collision_retry == $past(i_wdata[TC_LATE_RETRY]))
        else $error("retry wrong");
    AST_LOOP: assert property (
        tx_wr |=> o_loopback_select == $past(i_wdata[TC_LB_HI:TC_LB_LO]))
        else $error("loopback wrong");
    AST_CRC: assert property (
        tx_wr |=> o_append_crc != $past(i_wdata[TC_NO_CRC]))
        else $error("crc append wrong");
    AST_WIDTH: assert property (
        i_wr && i_addr == OFS_DP_CFG |=> o_word_transfer_select == $past(i_wdata[DC_WTS]))
        else $error("width wrong");
    AST_DUPLEX: assert property (
        i_internal_phy || i_media_control_fdx |-> o_full_duplex != i_internal_phy)
        else $error("duplex wrong");
    AST_STATUS: assert property (
        i_addr == OFS_RX_CFG |-> !o_rdata[RS_ZERO_BIT] && !o_rdata[RS_RSVD])
        else $error("status zero bits set");
    AST_MONITOR: assert property (
        rc_r[RC_MONITOR] |-> !o_rx_store)
        else $error("stored in monitor mode");
endmodule : mac_cfg_chk
`default_nettype wire

// ### mac_host_model.sv
// Host side model: one-cycle register reads and writes
`timescale 1ns/10ps
`default_nettype none
module mac_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [3:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 14'h0000;
    // Idle bus carries inverted values so stale data is never trusted
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge i_clk) {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_clk) q = i_rdata;
        @(negedge i_clk) {o_wr, o_rd, o_addr, o_wdata} = {2'h0, ~a, ~d};
    endtask : xfer
endmodule : mac_host_model
`default_nettype wire

// ### mac_rx_tx_config_regs_tb_top.sv
// Self-checking bench for the MAC config register bank
`timescale 1ns/10ps
`default_nettype none
module mac_rx_tx_config_regs_tb_top;
    import mac_cfg_pkg::*;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic i_wr, i_rd, o_rx_accept, o_rx_store, o_full_duplex, o_pad_enable, o_irq;
    logic o_late_collision_retry, o_append_crc, o_word_transfer_select;
    logic [1:0] o_loopback_select;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic i_rx_done = 1'h0, i_rx_da_match = 1'h0, i_rx_da_multicast = 1'h0;
    logic i_rx_da_broadcast = 1'h0, i_rx_hash_hit = 1'h0, i_rx_short = 1'h0;
    logic i_rx_align_err = 1'h0, i_rx_crc_err = 1'h0, i_rx_missed = 1'h0;
    logic i_rx_disabled = 1'h0, i_media_control_fdx = 1'h0, i_internal_phy = 1'h0;
    logic [6:0] src = 7'h00;
    wire logic i_dma_done = src[IRQ_DMA];
    wire logic i_ring_overwrite = src[IRQ_OVW];
    wire logic i_tx_error = src[IRQ_TXE];
    wire logic i_tx_done = src[IRQ_PTX];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    mac_rx_tx_config_regs i_mac_rx_tx_config_regs (.*);
    mac_host_model i_mac_host_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            give_verdict;
        end
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_mac_host_model.xfer(1'h1, a, d, x);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        logic [7:0] x;
        i_mac_host_model.xfer(1'h0, a, 8'h00, x);
        chk("rdata", x & m, e);
    endtask : rd
    // Flags b: match, multicast, broadcast, hash hit, short, align, crc, missed
    task automatic frame(input logic [7:0] cfg, input logic [7:0] b, input logic a, s);
        wr(OFS_RX_CFG, cfg);
        {i_rx_done, i_rx_da_match, i_rx_da_multicast, i_rx_da_broadcast, i_rx_hash_hit,
            i_rx_short, i_rx_align_err, i_rx_crc_err, i_rx_missed} = {1'h1, b};
        #1 chk("accept", o_rx_accept, a);
        chk("store", o_rx_store, s);
        @(negedge i_clk) i_rx_done = 1'h0;
    endtask : frame
    task automatic t_reset;
        chk("pad", o_pad_enable, 8'h01);
        chk("crc", o_append_crc, 8'h01);
        chk("cfg", {o_late_collision_retry, o_loopback_select, o_full_duplex}, 8'h00);
        chk("width", o_word_transfer_select, 8'h00);
        chk("irq", o_irq, 8'h00);
        rd(OFS_TX_CFG, 8'h00);
        rd(OFS_DP_CFG, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_tx;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_TX_CFG, {k[1], k[0], k[1], 2'h3, 2'(k), k[0]});
            chk("loop", o_loopback_select, 8'(k));
            chk("pad", o_pad_enable, 8'(!k[0]));
            chk("crc", o_append_crc, 8'(!k[0]));
            chk("retry", o_late_collision_retry, 8'(k[1]));
            chk("fdx", o_full_duplex, 8'(k[1]));
        end
        wr(OFS_TX_CFG, 8'h00);
        // Levels are held across a clock edge so the duplex assertion sees them
        i_media_control_fdx = 1'h1;
        @(negedge i_clk);
        chk("fdx", o_full_duplex, 8'h01);
        i_internal_phy = 1'h1;
        @(negedge i_clk);
        chk("fdx", o_full_duplex, 8'h00);
        i_media_control_fdx = 1'h0;
        @(negedge i_clk);
        chk("fdx", o_full_duplex, 8'h00);
        i_internal_phy = 1'h0;
        wr(OFS_DP_CFG, 8'hFF);
        chk("width", o_word_transfer_select, 8'h01);
        wr(OFS_DP_CFG, 8'h00);
        chk("width", o_word_transfer_select, 8'h00);
        $display("transmit config test done");
    endtask : t_tx
    task automatic t_filter;
        frame(8'h10, 8'h00, 1'h1, 1'h1);
        frame(8'h00, 8'h00, 1'h0, 1'h0);
        frame(8'h08, 8'h50, 1'h1, 1'h1);
        frame(8'h08, 8'h40, 1'h0, 1'h0);
        frame(8'h04, 8'h60, 1'h1, 1'h1);
        frame(8'h00, 8'h60, 1'h0, 1'h0);
        frame(8'h00, 8'h88, 1'h0, 1'h0);
        frame(8'h02, 8'h88, 1'h1, 1'h1);
        frame(8'h00, 8'h82, 1'h0, 1'h0);
        frame(8'h01, 8'h82, 1'h1, 1'h1);
        frame(8'h20, 8'h80, 1'h1, 1'h0);
        $display("filter test done");
    endtask : t_filter
    task automatic t_status;
        i_rx_disabled = 1'h1;
        frame(8'h00, 8'h41, 1'h0, 1'h0);
        rd(OFS_RX_CFG, 8'h70);
        i_rx_disabled = 1'h0;
        frame(8'h00, 8'h80, 1'h1, 1'h1);
        rd(OFS_RX_CFG, 8'h01);
        $display("status test done");
    endtask : t_status
    task automatic t_tally;
        rd(OFS_DP_CFG, 8'h02);
        rd(OFS_DP_CFG, 8'h00);
        frame(8'h00, 8'h04, 1'h0, 1'h0);
        frame(8'h00, 8'h02, 1'h0, 1'h0);
        rd(OFS_TX_CFG, 8'h00);
        rd(OFS_DP_CFG, 8'h00);
        wr(OFS_IRQ_STATUS, 8'h7F);
        for (int n = 0; n < 128; n++) begin
            frame(8'h00, 8'h84, 1'h0, 1'h0);
        end
        chk("irq", o_irq, 8'h00);
        rd(OFS_IRQ_STATUS, 8'h20, 8'h20);
        wr(OFS_IRQ_MASK, 8'h20);
        chk("irq", o_irq, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h20);
        chk("irq", o_irq, 8'h00);
        wr(OFS_IRQ_MASK, 8'h00);
        rd(OFS_TX_CFG, 8'h80);
        $display("tally test done");
    endtask : t_tally
    task automatic t_one_src(input int k);
        wr(OFS_IRQ_STATUS, 8'h7F);
        @(negedge i_clk) src[k] = 1'h1;
        @(negedge i_clk) src[k] = 1'h0;
        rd(OFS_IRQ_STATUS, 8'(1 << k));
        wr(OFS_IRQ_MASK, 8'h7F ^ 8'(1 << k));
        chk("irq", o_irq, 8'h00);
        wr(OFS_IRQ_MASK, 8'(1 << k));
        chk("irq", o_irq, 8'h01);
        wr(OFS_IRQ_STATUS, 8'(1 << k));
        chk("irq", o_irq, 8'h00);
    endtask : t_one_src
    task automatic t_irq;
        t_one_src(IRQ_PTX);
        t_one_src(IRQ_TXE);
        t_one_src(IRQ_OVW);
        t_one_src(IRQ_DMA);
        // Receive flags come from frames, not from the source pulses
        wr(OFS_IRQ_STATUS, 8'h7F);
        frame(8'h00, 8'h82, 1'h0, 1'h0);
        frame(8'h00, 8'h80, 1'h1, 1'h1);
        rd(OFS_IRQ_STATUS, 8'h05);
        wr(OFS_IRQ_MASK, 8'h01);
        chk("irq", o_irq, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h01);
        chk("irq", o_irq, 8'h00);
        wr(OFS_IRQ_MASK, 8'h04);
        chk("irq", o_irq, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h04);
        chk("irq", o_irq, 8'h00);
        wr(OFS_IRQ_MASK, 8'h00);
        $display("interrupt test done");
    endtask : t_irq
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(negedge i_clk);
        i_srst = 1'h0;
        t_reset;
        t_tx;
        t_filter;
        t_status;
        t_tally;
        t_irq;
        give_verdict;
    end
endmodule : mac_rx_tx_config_regs_tb_top
bind mac_rx_tx_config_regs mac_cfg_chk i_mac_cfg_chk (.*);
`default_nettype wire
